// ### src/ums_map.svh
// Purpose: offsets, field positions, reset values for modem and line status block
// Assumes: byte-wide registers at printed offsets
// Notes: none
`ifndef UMS_MAP_SVH
`define UMS_MAP_SVH
`define UMS_OFF_MODEM_CONTROL 3'h4
`define UMS_OFF_LINE_STATUS 3'h5
`define UMS_OFF_MODEM_STATUS 3'h6
`define UMS_OFF_SCRATCH_BYTE 3'h7
`define UMS_CTL_DTR 0
`define UMS_CTL_RTS 1
`define UMS_CTL_USER_OUTPUT_FLAG_ONE 2
`define UMS_CTL_USER_OUTPUT_FLAG_TWO 3
`define UMS_CTL_LOOP 4
`define UMS_CTL_RESET 5'h00
`define UMS_SCRATCH_RESET 8'h00
`define UMS_MODEM_IN_RESET 4'hf
`endif

// ### src/ums_pkg.sv
// Purpose: types for the modem and line status block
// Assumes: nothing
// Notes: modem lines packed cts, dsr, ri, dcd from bit 0
package ums_pkg;
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ums_modem_s;
  typedef struct packed {
    logic char_done;
    logic overrun;
    logic parity_err;
    logic framing_err;
    logic break_det;
    logic rx_nonempty;
    logic fifo_err_pending;
  } ums_rx_s;
  typedef struct packed {
    logic [4:0] ctrl;
    logic [7:0] scratch;
    logic [7:0] rdata;
    logic oe;
    logic par_err;
    logic frm_err;
    logic brk;
    logic [3:0] delta;
    ums_modem_s prev;
    logic dtr_n;
    logic rts_n;
    logic txd;
    logic ser_in;
    logic int_oe;
    logic int_out;
    logic lsi;
    logic msi;
  } ums_state_s;
endpackage

// ### src/ums_top.sv
// Purpose: modem control, line status, modem status and scratch registers
// Assumes: receiver, transmitter and fifo logic outside supply event pulses and levels
// Notes: pin inputs synchronous to clk
// How it works
// - control bit 0 set drives terminal ready pin low, clear drives it high
// - control bit 1 drives request to send pin with the same inversion
// - control bit 2 is stored only, used in loopback
// - control bit 3 enables the port interrupt pin, else pin released
// - loopback holds transmit pin high and feeds shifter output to receiver
// - loopback ignores modem inputs, maps control outputs, forces terminal ready and request to send pins high
// - loopback interrupts stay live, modem changes come from control bits
// - control bits 5 to 7 read zero
// - data ready follows receive buffer or fifo holding data
// - overrun sets on overwrite event, clears on line status read
// - parity error sets with its character, clears on line status read
// - framing error sets with its character, clears on read
// - break sets with its character, clears on line status read
// - receiver restarts after break only after half bit of marking
// - any error bit raises line status interrupt when enabled
// - holding empty flag reflects holding register or fifo empty, read only
// - transmitter empty only when holding and shift registers both empty
// - bit 7 zero without fifo, else follows the fifo error pending input, not cleared here
// - change bits for clear to send, data set ready, carrier detect set on change
// - ring change bit sets on ring input trailing edge
// - any change bit raises modem status interrupt when enabled
// - upper status bits show inverted inputs, or control bits in loopback
`timescale 1ns/100ps
`default_nettype none
`include "ums_map.svh"
module ums_top
  import ums_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire ums_rx_s rx_ev,
  input wire logic fifo_mode,
  input wire logic holding_empty,
  input wire logic shift_empty,
  input wire logic ier_line_status,
  input wire logic ier_modem_status,
  input wire logic tx_shift_out,
  input wire logic rxd,
  input wire logic uart_int_req,
  input wire ums_modem_s modem_in_n,
  output logic serial_out,
  output logic receiver_serial_in,
  output logic terminal_ready_n,
  output logic request_to_send_n,
  output logic port_int,
  output logic port_int_oe,
  output logic line_status_int,
  output logic modem_status_int
);
  ums_state_s st_r, st_nxt;

  // effective active-high modem lines as seen by the status logic
  function automatic ums_modem_s eff_lines(input logic [4:0] ctrl, input ums_modem_s pins_n);
    ums_modem_s m;
    if (ctrl[`UMS_CTL_LOOP]) begin
      m.cts = ctrl[`UMS_CTL_RTS];
      m.dsr = ctrl[`UMS_CTL_DTR];
      m.ri = ctrl[`UMS_CTL_USER_OUTPUT_FLAG_ONE];
      m.dcd = ctrl[`UMS_CTL_USER_OUTPUT_FLAG_TWO];
    end else begin
      m = ~pins_n;
    end
    return m;
  endfunction

  ums_modem_s lines;
  logic [7:0] line_val, mstat_val;
  logic line_rd, mstat_rd, loop;

  always_comb begin
    loop = st_r.ctrl[`UMS_CTL_LOOP];
    lines = eff_lines(st_r.ctrl, modem_in_n);
    line_val = {fifo_mode & rx_ev.fifo_err_pending,
                holding_empty & shift_empty,
                holding_empty,
                st_r.brk, st_r.frm_err, st_r.par_err, st_r.oe,
                rx_ev.rx_nonempty};
    mstat_val = {lines.dcd, lines.ri, lines.dsr, lines.cts, st_r.delta};
    line_rd = rd_stb & (addr == `UMS_OFF_LINE_STATUS);
    mstat_rd = rd_stb & (addr == `UMS_OFF_MODEM_STATUS);
    st_nxt = st_r;
    if (wr_stb && addr == `UMS_OFF_MODEM_CONTROL) begin
      st_nxt.ctrl = wdata[4:0];
    end
    if (wr_stb && addr == `UMS_OFF_SCRATCH_BYTE) begin
      st_nxt.scratch = wdata;
    end
    st_nxt.rdata = 8'h00;
    if (rd_stb) begin
      unique case (addr)
        `UMS_OFF_MODEM_CONTROL: st_nxt.rdata = {3'h0, st_r.ctrl};
        `UMS_OFF_LINE_STATUS: st_nxt.rdata = line_val;
        `UMS_OFF_MODEM_STATUS: st_nxt.rdata = mstat_val;
        `UMS_OFF_SCRATCH_BYTE: st_nxt.rdata = st_r.scratch;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // read clears, but an event in the same cycle wins
    if (line_rd) begin
      st_nxt.oe = 1'b0;
      st_nxt.par_err = 1'b0;
      st_nxt.frm_err = 1'b0;
      st_nxt.brk = 1'b0;
    end
    if (rx_ev.overrun) st_nxt.oe = 1'b1;
    if (rx_ev.char_done) begin
      // per-character flags arrive as the character reaches the top
      if (rx_ev.parity_err) st_nxt.par_err = 1'b1;
      if (rx_ev.framing_err) st_nxt.frm_err = 1'b1;
      if (rx_ev.break_det) st_nxt.brk = 1'b1;
    end
    if (mstat_rd) st_nxt.delta = 4'h0;
    st_nxt.prev = lines;
    if (lines.cts != st_r.prev.cts) st_nxt.delta[0] = 1'b1;
    if (lines.dsr != st_r.prev.dsr) st_nxt.delta[1] = 1'b1;
    if (lines.dcd != st_r.prev.dcd) st_nxt.delta[3] = 1'b1;
    if (st_r.prev.ri && !lines.ri) st_nxt.delta[2] = 1'b1;
    st_nxt.dtr_n = loop | ~st_r.ctrl[`UMS_CTL_DTR];
    st_nxt.rts_n = loop | ~st_r.ctrl[`UMS_CTL_RTS];
    st_nxt.txd = loop | tx_shift_out;
    // break restart timing lives in the receiver, which sees this line
    st_nxt.ser_in = loop ? tx_shift_out : rxd;
    st_nxt.int_oe = st_r.ctrl[`UMS_CTL_USER_OUTPUT_FLAG_TWO];
    st_nxt.int_out = uart_int_req & st_r.ctrl[`UMS_CTL_USER_OUTPUT_FLAG_TWO];
    st_nxt.lsi = ier_line_status & (st_r.oe | st_r.par_err | st_r.frm_err | st_r.brk);
    st_nxt.msi = ier_modem_status & (|st_r.delta);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.ctrl <= `UMS_CTL_RESET;
      st_r.scratch <= `UMS_SCRATCH_RESET;
      st_r.rdata <= 8'h00;
      st_r.oe <= 1'b0;
      st_r.par_err <= 1'b0;
      st_r.frm_err <= 1'b0;
      st_r.brk <= 1'b0;
      st_r.delta <= 4'h0;
      st_r.prev <= 4'h0;
      st_r.dtr_n <= 1'b1;
      st_r.rts_n <= 1'b1;
      st_r.txd <= 1'b1;
      st_r.ser_in <= 1'b1;
      st_r.int_oe <= 1'b0;
      st_r.int_out <= 1'b0;
      st_r.lsi <= 1'b0;
      st_r.msi <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign serial_out = st_r.txd;
  assign receiver_serial_in = st_r.ser_in;
  assign terminal_ready_n = st_r.dtr_n;
  assign request_to_send_n = st_r.rts_n;
  assign port_int = st_r.int_out;
  assign port_int_oe = st_r.int_oe;
  assign line_status_int = st_r.lsi;
  assign modem_status_int = st_r.msi;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: register level test of the modem and line status block
// Assumes: read data one cycle after the strobe
// Notes: rx events are fed as pulses, no real receiver
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ums_pkg::*;
;
  logic clk = 0, reset = 1, wr_stb = 0, rd_stb = 0, fifo_mode = 0, h_empty = 1, s_empty = 1;
  logic ie_ls = 1, ie_ms = 1, tx_bit = 1, rxd = 1, int_req = 0;
  logic dtr_n, rts_n, sout, rsin, pint, poe, lsi, msi;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  ums_rx_s rx_ev = 7'h00;
  ums_modem_s want = 4'hf, pins;
  logic [6:0] ev [1:4] = '{7'h22, 7'h52, 7'h4a, 7'h46};
  int miscompares = 0, n_checks = 0;
  ums_modem_model dce (.clk(clk), .want(want), .modem_in_n(pins));
  ums_top uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .rx_ev(rx_ev), .fifo_mode(fifo_mode), .holding_empty(h_empty), .shift_empty(s_empty),
    .ier_line_status(ie_ls), .ier_modem_status(ie_ms), .tx_shift_out(tx_bit), .rxd(rxd),
    .uart_int_req(int_req), .modem_in_n(pins), .serial_out(sout), .receiver_serial_in(rsin),
    .terminal_ready_n(dtr_n), .request_to_send_n(rts_n), .port_int(pint), .port_int_oe(poe),
    .line_status_int(lsi), .modem_status_int(msi));
  initial forever #20 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) wr_stb <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr_stb <= 0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk) rd_stb <= 1;
    addr <= a;
    @(posedge clk) rd_stb <= 0;
    #1 chk(rdata, e);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far beyond the longest sequence
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    wr(3'h7, 8'ha5);
    rd(3'h7, 8'ha5);
    rd(3'h2, 8'h00);
    wr(3'h4, 8'hed);
    int_req <= 1;
    rd(3'h4, 8'h0d);
    chk({dtr_n, rts_n, poe, pint}, 8'h07);
    $display("test control done");
    want <= 4'h0;
    repeat (3) @(posedge clk);
    #1 chk(msi, 8'h01);
    rd(3'h6, 8'hfb);
    want <= 4'hf;
    repeat (3) @(posedge clk);
    rd(3'h6, 8'h0f);
    rd(3'h6, 8'h00);
    $display("test modem done");
    wr(3'h4, 8'h1b);
    tx_bit <= 0;
    rd(3'h6, 8'hbb);
    want <= 4'h0;
    repeat (3) @(posedge clk);
    chk({sout, rsin, dtr_n, rts_n}, 8'h0b);
    rd(3'h6, 8'hb0);
    wr(3'h4, 8'h19);
    rd(3'h6, 8'ha1);
    tx_bit <= 1;
    wr(3'h4, 8'h08);
    rd(3'h6, 8'hf1);
    rxd <= 0;
    tx_bit <= 0;
    repeat (2) @(posedge clk);
    #1 chk({sout, rsin}, 8'h00);
    rxd <= 1;
    $display("test loopback done");
    s_empty <= 0;
    rx_ev <= 7'h02;
    for (int i = 1; i < 5; i++) begin
      @(posedge clk) rx_ev <= ev[i];
      @(posedge clk) rx_ev <= 7'h02;
      repeat (2) @(posedge clk);
      #1 chk(lsi, 8'h01);
      rd(3'h5, 8'h21 | (8'h01 << i));
      rd(3'h5, 8'h21);
    end
    fifo_mode <= 1;
    rx_ev <= 7'h03;
    rd(3'h5, 8'ha1);
    $display("test line status done");
    give_verdict;
  end
endmodule
`default_nettype wire

// ### verif/ums_modem_model.sv
// Purpose: data set on the modem handshake lines
// Assumes: lines move just after a clock edge
// Notes: bench sets want, pins follow one edge later
`timescale 1ns/100ps
`default_nettype none
module ums_modem_model
  import ums_pkg::*;
(
  input wire logic clk,
  input wire ums_modem_s want,
  output ums_modem_s modem_in_n
);
  // registered so pin moves never race the sampling edge
  always_ff @(posedge clk) modem_in_n <= want;
endmodule
`default_nettype wire

// ### verif/ums_top_sva.sv
// Purpose: port checks for the modem and line status block
// Assumes: pins follow a control write two edges later
// Notes: bound into every ums_top
`timescale 1ns/100ps
`default_nettype none
module ums_sva
  import ums_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire ums_rx_s rx_ev,
  input wire logic fifo_mode,
  input wire logic holding_empty,
  input wire logic shift_empty,
  input wire logic ier_line_status,
  input wire logic uart_int_req,
  input wire logic serial_out,
  input wire logic terminal_ready_n,
  input wire logic request_to_send_n,
  input wire logic port_int,
  input wire logic port_int_oe,
  input wire logic line_status_int
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wr_mc; wr_stb && addr == 3'h4; endsequence
  sequence s_rd_ls; rd_stb && addr == 3'h5; endsequence
  property p_pins; s_wr_mc ##0 !wdata[4] |-> ##2 {terminal_ready_n, request_to_send_n} == ~{$past(wdata[0], 2), $past(wdata[1], 2)}; endproperty
  property p_loop; s_wr_mc ##0 wdata[4] |-> ##2 terminal_ready_n && request_to_send_n && serial_out; endproperty
  property p_oe; s_wr_mc |-> ##2 port_int_oe == $past(wdata[3], 2); endproperty
  property p_gate; port_int |-> port_int_oe && $past(uart_int_req); endproperty
  property p_mc_rd; rd_stb && addr == 3'h4 |=> rdata[7:5] == 3'h0; endproperty
  property p_ls; s_rd_ls |=> rdata[0] == $past(rx_ev.rx_nonempty) && rdata[6:5] == $past({shift_empty && holding_empty, holding_empty}); endproperty
  property p_b7; s_rd_ls ##0 !fifo_mode |=> !rdata[7]; endproperty
  property p_ovr; rx_ev.overrun && ier_line_status && !rd_stb |-> ##[1:2] line_status_int; endproperty
  a_pins: assert property (p_pins) else $error("control pins wrong");
  a_loop: assert property (p_loop) else $error("loopback pins not high");
  a_oe: assert property (p_oe) else $error("interrupt enable pin wrong");
  a_gate: assert property (p_gate) else $error("interrupt not gated");
  a_mc_rd: assert property (p_mc_rd) else $error("control top bits set");
  a_ls: assert property (p_ls) else $error("status levels wrong");
  a_b7: assert property (p_b7) else $error("bit 7 set without fifo");
  a_ovr: assert property (p_ovr) else $error("no line interrupt");
endmodule
bind ums_top ums_sva u_sva (.clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .rx_ev, .fifo_mode,
  .holding_empty, .shift_empty, .ier_line_status, .uart_int_req, .serial_out, .terminal_ready_n,
  .request_to_send_n, .port_int, .port_int_oe, .line_status_int);
`default_nettype wire
